// ### include/wdog_consts.svh
// constants for the slave controller watchdog pair
// How it works
// - expiry forces outputs to preset safe value
// - sync manager watchdog defaults to 100 ms
// - interface watchdog also defaults to 100 ms
// - one multiplier sets tick for both
// - own timer count per watchdog, shared multiplier
// - undownloaded settings keep their held value
// - multiplier and timers read back as in effect
// - tick is multiplier plus two 40 ns periods
// - process data exchange restarts sync watchdog
// - interface watchdog trips without local access
// - zero sync timer disables that watchdog
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH
`define ADDR_MULT        16'h0400
`define ADDR_APP_TIMER   16'h0410
`define ADDR_SYNC_TIMER  16'h0420
`define ADDR_STATUS      16'h0440
`define RST_MULT         16'h09C2
`define RST_TIMER        16'h03E8
`define STAT_SYNC_BIT    0
`define STAT_APP_BIT     1
`define BASE_TICK_NS     40
`define CLK_PERIOD_NS    10
`define BASE_TICK_CYC    ((`BASE_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### include/wdog_pkg.sv
// types shared by the watchdog pair
package wdog_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef enum logic [0:0] {
    WD_RUN     = 1'b0,
    WD_EXPIRED = 1'b1
  } wd_state_t;
endpackage

// ### design/wd_timer.sv
// one watchdog counter that counts shared ticks up to the period for expiry
`timescale 1ns/1ps
module wd_timer (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              tick,
  input  wire logic              kick,
  input  wire logic [15:0]       period,
  output wdog_pkg::wd_state_t    state,
  output logic                   expire_pulse
);
  logic [15:0]         cnt_reg;
  logic [15:0]         cnt_next;
  wdog_pkg::wd_state_t st_reg;
  wdog_pkg::wd_state_t st_next;

  always_comb begin
    cnt_next     = cnt_reg;
    st_next      = st_reg;
    expire_pulse = 1'b0;
    if (period == 16'h0000) begin
      // zero timer: watchdog fully off
      cnt_next = 16'h0000;
      st_next  = wdog_pkg::WD_RUN;
    end else if (kick) begin
      cnt_next = 16'h0000;
      st_next  = wdog_pkg::WD_RUN;
    end else if (tick && st_reg == wdog_pkg::WD_RUN) begin
      if (cnt_reg + 16'h0001 >= period) begin
        st_next      = wdog_pkg::WD_EXPIRED;
        expire_pulse = ce;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      st_reg  <= wdog_pkg::WD_RUN;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      st_reg  <= st_next;
    end
  end

  assign state = st_reg;
endmodule

// ### design/slave_comm_watchdog_pair.sv
// watchdog pair with registers, shared tick and safe output forcing
`timescale 1ns/1ps
`include "wdog_consts.svh"
module slave_comm_watchdog_pair (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              CE,
  input  wire wdog_pkg::reg_req_t REQ,
  output logic [15:0]            RDATA,
  output logic                   RVALID,
  input  wire logic              PD_EXCHANGE,
  input  wire logic              APP_ACCESS,
  input  wire logic [7:0]        OUT_DATA,
  input  wire logic [7:0]        SAFE_VALUE,
  output logic [7:0]             OUT_PINS,
  output logic                   SYNC_EXPIRED,
  output logic                   APP_EXPIRED
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] mult_reg, mult_next;
  logic [15:0] app_tmr_reg, app_tmr_next;
  logic [15:0] sync_tmr_reg, sync_tmr_next;
  logic [1:0]  sticky_reg, sticky_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [7:0]  out_reg, out_next;
  logic [16:0] base_reg, base_next;
  logic [1:0]  pre_reg, pre_next;
  logic        tick;
  logic        sync_exp_p, app_exp_p;
  wdog_pkg::wd_state_t sync_st, app_st;

  always_comb begin
    mult_next     = mult_reg;
    app_tmr_next  = app_tmr_reg;
    sync_tmr_next = sync_tmr_reg;
    rdata_next    = 16'h0000;
    rvalid_next   = REQ.rd;
    // only written addresses change; others hold their value
    if (REQ.wr) begin
      unique case (REQ.addr)
        `ADDR_MULT:       mult_next     = REQ.wdata;
        `ADDR_APP_TIMER:  app_tmr_next  = REQ.wdata;
        `ADDR_SYNC_TIMER: sync_tmr_next = REQ.wdata;
        default:          mult_next     = mult_reg;
      endcase
    end
    if (REQ.rd) begin
      unique case (REQ.addr)
        `ADDR_MULT:       rdata_next = mult_reg;
        `ADDR_APP_TIMER:  rdata_next = app_tmr_reg;
        `ADDR_SYNC_TIMER: rdata_next = sync_tmr_reg;
        `ADDR_STATUS:     rdata_next = {14'h0000, sticky_reg};
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // shared tick: (mult + 2) base ticks of 40 ns
  // ---------------------------------------------------------------
  always_comb begin
    pre_next  = pre_reg;
    base_next = base_reg;
    tick      = 1'b0;
    if (pre_reg == 2'(`BASE_TICK_CYC - 1)) begin
      pre_next = 2'h0;
      // 17 bits so the largest multiplier still counts in full
      if (base_reg >= {1'b0, mult_reg} + 17'h00001) begin
        base_next = 17'h00000;
        tick      = 1'b1;
      end else begin
        base_next = base_reg + 17'h00001;
      end
    end else begin
      pre_next = pre_reg + 2'h1;
    end
  end

  wd_timer u_sync (
    .clk          (CLK),
    .rstn         (RSTN),
    .ce           (CE),
    .tick         (tick),
    .kick         (PD_EXCHANGE),
    .period       (sync_tmr_reg),
    .state        (sync_st),
    .expire_pulse (sync_exp_p)
  );

  wd_timer u_app (
    .clk          (CLK),
    .rstn         (RSTN),
    .ce           (CE),
    .tick         (tick),
    .kick         (APP_ACCESS),
    .period       (app_tmr_reg),
    .state        (app_st),
    .expire_pulse (app_exp_p)
  );

  // ---------------------------------------------------------------
  // sticky flags and safe outputs
  // ---------------------------------------------------------------
  always_comb begin
    sticky_next = sticky_reg;
    // set wins over the clearing access in the same cycle
    if (PD_EXCHANGE)
      sticky_next[`STAT_SYNC_BIT] = 1'b0;
    if (APP_ACCESS)
      sticky_next[`STAT_APP_BIT] = 1'b0;
    if (sync_exp_p)
      sticky_next[`STAT_SYNC_BIT] = 1'b1;
    if (app_exp_p)
      sticky_next[`STAT_APP_BIT] = 1'b1;
    if (sync_st == wdog_pkg::WD_EXPIRED ||
        app_st == wdog_pkg::WD_EXPIRED)
      out_next = SAFE_VALUE;
    else
      out_next = OUT_DATA;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mult_reg     <= `RST_MULT;
      app_tmr_reg  <= `RST_TIMER;
      sync_tmr_reg <= `RST_TIMER;
      sticky_reg   <= 2'h0;
      rdata_reg    <= 16'h0000;
      rvalid_reg   <= 1'b0;
      out_reg      <= 8'h00;
      base_reg     <= 17'h00000;
      pre_reg      <= 2'h0;
    end else if (CE) begin
      mult_reg     <= mult_next;
      app_tmr_reg  <= app_tmr_next;
      sync_tmr_reg <= sync_tmr_next;
      sticky_reg   <= sticky_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      out_reg      <= out_next;
      base_reg     <= base_next;
      pre_reg      <= pre_next;
    end
  end

  assign RDATA        = rdata_reg;
  assign RVALID       = rvalid_reg;
  assign OUT_PINS     = out_reg;
  assign SYNC_EXPIRED = sticky_reg[`STAT_SYNC_BIT];
  assign APP_EXPIRED  = sticky_reg[`STAT_APP_BIT];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  safe_force_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && sync_st == wdog_pkg::WD_EXPIRED |=> OUT_PINS == $past(SAFE_VALUE))
    else $error("outputs not forced safe");
  zero_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && sync_tmr_reg == 16'h0000
    |-> !sync_exp_p ##1 sync_st == wdog_pkg::WD_RUN)
    else $error("zero timer did not disable");
  kick_run_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && PD_EXCHANGE |=> sync_st == wdog_pkg::WD_RUN)
    else $error("exchange did not restart");
  app_kick_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && APP_ACCESS |=> app_st == wdog_pkg::WD_RUN)
    else $error("access did not restart");
  sticky_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
    sync_exp_p |=> SYNC_EXPIRED)
    else $error("sticky flag not set");
  write_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !(REQ.wr && REQ.addr == `ADDR_MULT) |=> $stable(mult_reg))
    else $error("multiplier changed without write");
  readback_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && REQ.rd && REQ.addr == `ADDR_SYNC_TIMER
    |=> RVALID && RDATA == $past(sync_tmr_reg))
    else $error("timer readback wrong");
  tick_space_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && tick |=> !tick [*3])
    else $error("ticks too close");

  // ---------------------------------------------------------------
  // checks on flags, outputs and registers
  // ---------------------------------------------------------------
  app_safe_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && app_st == wdog_pkg::WD_EXPIRED |=> OUT_PINS == $past(SAFE_VALUE))
    else $error("interface expiry not forced safe");
  pass_through_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && sync_st == wdog_pkg::WD_RUN && app_st == wdog_pkg::WD_RUN
    |=> OUT_PINS == $past(OUT_DATA))
    else $error("normal output data not passed");
  app_sticky_a: assert property (@(posedge CLK) disable iff (!RSTN)
    app_exp_p |=> APP_EXPIRED)
    else $error("interface sticky flag not set");
  sync_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && PD_EXCHANGE |=> !SYNC_EXPIRED)
    else $error("exchange did not clear flag");
  app_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && APP_ACCESS |=> !APP_EXPIRED)
    else $error("access did not clear flag");
  sync_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !PD_EXCHANGE && SYNC_EXPIRED |=> SYNC_EXPIRED)
    else $error("sync flag dropped without exchange");
  app_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !APP_ACCESS && APP_EXPIRED |=> APP_EXPIRED)
    else $error("interface flag dropped without access");
  expire_tick_a: assert property (@(posedge CLK) disable iff (!RSTN)
    sync_exp_p || app_exp_p |-> tick)
    else $error("expiry off the tick");
  mult_write_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && REQ.wr && REQ.addr == `ADDR_MULT |=> mult_reg == $past(REQ.wdata))
    else $error("multiplier write lost");
  app_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !(REQ.wr && REQ.addr == `ADDR_APP_TIMER) |=> $stable(app_tmr_reg))
    else $error("interface timer changed without write");
  sync_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !(REQ.wr && REQ.addr == `ADDR_SYNC_TIMER)
    |=> $stable(sync_tmr_reg))
    else $error("sync timer changed without write");
  mult_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && REQ.rd && REQ.addr == `ADDR_MULT
    |=> RVALID && RDATA == $past(mult_reg))
    else $error("multiplier readback wrong");
  app_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && REQ.rd && REQ.addr == `ADDR_APP_TIMER
    |=> RVALID && RDATA == $past(app_tmr_reg))
    else $error("interface timer readback wrong");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !REQ.rd |=> !RVALID && RDATA == 16'h0000)
    else $error("read data shown without read");
endmodule

// ### bench/master_model.sv
// fieldbus master side: register downloads and read-back
`timescale 1ns/1ps
module master_model (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output wdog_pkg::reg_req_t req
);
  // ----------------------------------------
  // bus cycles, driven at the falling edge
  // ----------------------------------------
  initial req = '0;

  // released fields show inverted values so stale data is never trusted
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    d = (rvalid === 1'b1) ? rdata : 16'hXXXX;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
  endtask

  // only the selected settings go out; the rest stay as held
  task automatic download(input logic [2:0] sel, input logic [15:0] mlt,
                          input logic [15:0] at, input logic [15:0] st);
    if (sel[0]) wr(16'h0400, mlt);
    if (sel[1]) wr(16'h0410, at);
    if (sel[2]) wr(16'h0420, st);
  endtask
endmodule

// ### bench/tb_slave_comm_watchdog_pair.sv
// self-checking bench for the watchdog pair
`timescale 1ns/1ps
`include "wdog_consts.svh"
module tb_slave_comm_watchdog_pair;
  logic               clk, rstn, ce, pd, app, rvalid, sx, ax;
  logic [7:0]         od, sv, pins;
  logic [15:0]        rdata, v;
  wdog_pkg::reg_req_t req;
  int                 n_fail, checks, cyc, n, mlt, t;
  logic [15:0]        addr_t [5] = '{16'h0400, 16'h0410, 16'h0420,
                                     16'h0440, 16'h04F0};
  logic [15:0]        exp_t [5];

  slave_comm_watchdog_pair dut (.CLK(clk), .RSTN(rstn), .CE(ce),
    .REQ(req), .RDATA(rdata), .RVALID(rvalid), .PD_EXCHANGE(pd),
    .APP_ACCESS(app), .OUT_DATA(od), .SAFE_VALUE(sv), .OUT_PINS(pins),
    .SYNC_EXPIRED(sx), .APP_EXPIRED(ax));
  master_model m (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

  // ----------------------------------------
  // clock, timeout, compare and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic read_all();
    for (int i = 0; i < 5; i++) begin
      m.rd(addr_t[i], v);
      check(v, exp_t[i]);
    end
  endtask

  // one side goes silent; tick phase is free, so allow one tick short
  task automatic measure(input bit s, input int tk, input int tt);
    od = 8'($urandom);
    sv = ~od;
    @(negedge clk);
    pd = 1'b1;
    app = 1'b1;
    @(negedge clk);
    pd = s;
    app = !s;
    n = 0;
    while ((s ? ax : sx) !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= (tt - 1) * tk && n <= tt * tk + 4), 16'h0001);
    // outputs go safe one clock after the flag
    @(negedge clk);
    check(16'(pins), 16'(sv));
    check(16'(s ? sx : ax), 16'h0000);
    m.rd(16'h0440, v);
    check(v, s ? 16'h0002 : 16'h0001);
    pd = 1'b1;
    app = 1'b1;
    repeat (2) @(negedge clk);
    check(16'({sx, ax}), 16'h0000);
    check(16'(pins), 16'(od));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h75daf837));
    {rstn, pd, app, od, sv, n_fail, checks, cyc} = '0;
    ce = 1'b1;
    exp_t = '{16'h09C2, 16'h03E8, 16'h03E8, 16'h0000, 16'h0000};
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    read_all();
    m.download(3'b100, 16'h1111, 16'h2222, 16'h0005);
    exp_t[2] = 16'h0005;
    read_all();
    for (int i = 0; i < 6; i++) begin
      mlt = (i < 2) ? 0 : $urandom_range(3);
      t = $urandom_range(4, 2);
      m.download(3'b111, 16'(mlt), 16'(t), 16'(t));
      measure(i[0], `BASE_TICK_CYC * (mlt + 2), t);
    end
    m.download(3'b100, 16'h0000, 16'h0000, 16'h0000);
    pd = 1'b0;
    repeat (200) @(negedge clk);
    check(16'(sx), 16'h0000);
    check(16'(pins), 16'(od));
    // clock enable low: the write must not land; unmapped write ignored
    ce = 1'b0;
    m.wr(16'h0400, 16'h1234);
    ce = 1'b1;
    m.wr(16'h04F0, 16'h5A5A);
    m.rd(16'h0400, v);
    check(v, 16'(mlt));
    // reset in mid-run brings the defaults back
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    exp_t[2] = 16'h03E8;
    read_all();
    check(16'(pins), 16'(od));
    end_sim();
  end
endmodule
